// file: verilog/cpu_regs_pkg.sv
// Shared constants for the register set and operand address generator.
// Assumes a single 125 MHz clock domain; used as cpu_regs_pkg::name.
package cpu_regs_pkg;
  localparam int REG_W   = 32;  // General register and PC width
  localparam int PSW_W   = 16;  // State word width
  localparam int ADDR_W  = 24;  // External address width
  localparam int DATA_W  = 16;  // External data width
  localparam int SEL_W   = 5;   // Register select: 0..7 data, 8..14 addr, 15 active SP, 16 user SP
  localparam logic [4:0] SEL_SP  = 5'h0f;
  localparam logic [4:0] SEL_USP = 5'h10;
  localparam logic [4:0] NUM_REG = 5'h11;
  // State word field positions
  localparam int PSW_C = 0;
  localparam int PSW_V = 1;
  localparam int PSW_Z = 2;
  localparam int PSW_N = 3;
  localparam int PSW_X = 4;
  localparam int PSW_IM_LO = 8;
  localparam int PSW_IM_HI = 10;
  localparam int PSW_S = 13;
  localparam int PSW_T = 15;
  localparam logic [15:0] PSW_RESET = 16'h2700;  // Supervisor, mask level 7
  localparam logic [15:0] PSW_MASK  = 16'ha71f;  // Implemented bits
  localparam logic [31:0] PC_RESET  = 32'h00000000;
  // Operand sizes
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} opsize_t;
  // Address modes
  typedef enum logic [3:0] {
    AM_DREG, AM_AREG, AM_IND, AM_POSTINC, AM_PREDEC, AM_DISP, AM_INDEX,
    AM_ABS_SHORT, AM_ABS_LONG, AM_PC_DISP, AM_PC_INDEX, AM_IMPLIED
  } amode_t;
  // Implied targets
  typedef enum logic [1:0] {IMP_PSW, IMP_USP, IMP_SP, IMP_PC} implied_t;
endpackage : cpu_regs_pkg

// file: verilog/ea_adder.sv
// Operand address adder: base plus sign-extended index plus displacement.
// Pure combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module ea_adder (
  input  wire logic [31:0] baseVal,    // Base register or PC
  input  wire logic [31:0] indexVal,   // Index register contents
  input  wire logic        indexLong,  // Use full index, else low word
  input  wire logic        useIndex,   // Add the index term
  input  wire logic [15:0] dispVal,    // Raw displacement word
  input  wire logic        dispShort,  // Displacement is 8 bits
  output logic      [31:0] sumVal      // Resulting address
);
  // Sign-extend index and displacement to full width before adding
  logic [31:0] idxExt;
  logic [31:0] dispExt;
  assign idxExt  = !useIndex ? 32'h00000000 :
                   indexLong ? indexVal : {{16{indexVal[15]}}, indexVal[15:0]};
  assign dispExt = dispShort ? {{24{dispVal[7]}}, dispVal[7:0]}
                             : {{16{dispVal[15]}}, dispVal};
  assign sumVal  = baseVal + idxExt + dispExt;
endmodule : ea_adder
`default_nettype wire

// file: verilog/cpu_regs_ea.sv
// Programmer-visible register set and operand address generator.
// Assumes an instruction sequencer drives one request per cycle on mclk,
// already holds the extension words, and runs the bus cycles itself.
// How it works
// - Seventeen 32-bit registers, PC, 16-bit state
// - Data registers write byte, word, long
// - Address registers write word, long; byte size writes as word
// - Any of seventeen registers may index
// - State word holds three-bit interrupt mask
// - State word holds X N Z V C
// - State word holds trace and supervisor bits
// - Bus address 24 bits, data 16 bits
// - Absolute short/long from extension words
// - PC plus displacement, optionally plus index
// - Address register plus displacement, optional index
// - Postincrement: use register, then add step
// - Predecrement: subtract step, then use
// - Step is 1, 2 or 4
// - Byte step on stack pointer is 2
// - Implied mode selects state, USER_STACK_PTR, SP, PC
// - Word and long accesses at odd addresses raise alignErr
// - Word write to address register sign-extends
`timescale 1ns/100ps
`default_nettype none
module cpu_regs_ea (
  input  wire logic        mclk,          // 125 MHz clock
  input  wire logic        rst_n,         // Async reset, active low
  // Operand address request
  input  wire logic        eaReq,         // One-cycle request
  input  wire logic [3:0]  eaMode,        // Address mode
  input  wire logic [1:0]  eaSize,        // Operand size
  input  wire logic [4:0]  addrRegSel,    // Address register for indirect modes
  input  wire logic [4:0]  indexReg,      // Index register select
  input  wire logic        indexLong,     // Index uses long value
  input  wire logic [15:0] extWord0,      // First extension word
  input  wire logic [15:0] extWord1,      // Second extension word
  input  wire logic [1:0]  impliedSel,    // Implied target
  // Register write port
  input  wire logic        regWe,         // Write strobe
  input  wire logic [4:0]  regWrSel,      // Register to write
  input  wire logic [1:0]  regWrSize,     // Write size
  input  wire logic [31:0] regWrData,     // Write data
  // Program counter and state word
  input  wire logic        pcWe,          // Load program counter
  input  wire logic [31:0] pcWrData,      // New program counter
  input  wire logic        pswWe,         // Load state word
  input  wire logic [15:0] pswWrData,     // New state word
  input  wire logic        ccrWe,         // Load condition flags only
  input  wire logic [4:0]  ccrWrData,     // New X N Z V C
  // Register read port
  input  wire logic [4:0]  regRdSel,      // Register to read
  output logic      [31:0] regRdData,     // Registered read data
  // Results
  output logic             eaValid,       // Operand address ready, one cycle
  output logic      [31:0] operandLocation, // Full 32-bit operand address
  output logic      [23:0] busAddr,       // External address
  output logic             isRegOperand,  // Operand is a register
  output logic      [4:0]  operandReg,    // Register selected as operand
  output logic             alignErr,      // Odd address for word or long
  output logic      [31:0] progCounter,   // Program counter
  output logic      [15:0] processorStateWord, // State word
  output logic      [2:0]  intMask,       // Interrupt mask level
  output logic             supervisorMode, // Supervisor state
  output logic             traceMode      // Trace state
);
  // Register file: 0..7 data, 8..14 address, 15 supervisor SP, 16 user SP
  logic [31:0] regs_q [0:16];
  logic [31:0] pc_q;
  logic [15:0] psw_q;

  // Map a select onto a storage slot; 15 means the active stack pointer
  function automatic logic [4:0] slotOf(input logic [4:0] sel, input logic sup);
    if (sel == cpu_regs_pkg::SEL_SP && !sup) slotOf = cpu_regs_pkg::SEL_USP;
    else slotOf = sel;
  endfunction : slotOf

  // Step size for increment and decrement
  function automatic logic [31:0] stepOf(input logic [1:0] sz, input logic [4:0] slot);
    if (sz == cpu_regs_pkg::SZ_BYTE)
      stepOf = (slot >= cpu_regs_pkg::SEL_SP) ? 32'h00000002 : 32'h00000001;
    else if (sz == cpu_regs_pkg::SZ_WORD)
      stepOf = 32'h00000002;
    else
      stepOf = 32'h00000004;
  endfunction : stepOf

  wire         supNow   = psw_q[cpu_regs_pkg::PSW_S];
  wire  [4:0]  baseSlot = slotOf(addrRegSel, supNow);
  wire  [4:0]  idxSlot  = slotOf(indexReg, supNow);
  wire  [4:0]  wrSlot   = slotOf(regWrSel, supNow);
  wire  [4:0]  rdSlot   = slotOf(regRdSel, supNow);
  wire  [31:0] baseVal  = regs_q[baseSlot];
  wire  [31:0] idxVal   = (idxSlot < cpu_regs_pkg::NUM_REG) ? regs_q[idxSlot] : 32'h00000000;
  wire  [31:0] stepVal  = stepOf(eaSize, baseSlot);
  wire         isPost   = eaReq && (eaMode == cpu_regs_pkg::AM_POSTINC);
  wire         isPre    = eaReq && (eaMode == cpu_regs_pkg::AM_PREDEC);
  wire  [31:0] preVal   = baseVal - stepVal;
  wire  [31:0] postVal  = baseVal + stepVal;
  wire         pcBased  = (eaMode == cpu_regs_pkg::AM_PC_DISP) ||
                          (eaMode == cpu_regs_pkg::AM_PC_INDEX);
  wire         idxMode  = (eaMode == cpu_regs_pkg::AM_INDEX) ||
                          (eaMode == cpu_regs_pkg::AM_PC_INDEX);

  // Displacement sum for indexed and displacement modes
  logic [31:0] dispSum;
  ea_adder uAdder (
    .baseVal   (pcBased ? pc_q : baseVal),
    .indexVal  (idxVal),
    .indexLong (indexLong),
    .useIndex  (idxMode),
    .dispVal   (extWord0),
    .dispShort (idxMode),
    .sumVal    (dispSum)
  );

  // Implied target value
  logic [31:0] impVal;
  always_comb begin
    unique case (impliedSel)
      cpu_regs_pkg::IMP_PSW: impVal = {16'h0000, psw_q};
      cpu_regs_pkg::IMP_USP: impVal = regs_q[cpu_regs_pkg::SEL_USP];
      cpu_regs_pkg::IMP_SP:  impVal = regs_q[slotOf(cpu_regs_pkg::SEL_SP, supNow)];
      default:               impVal = pc_q;
    endcase
  end

  // Operand address selection per mode
  logic [31:0] eaNext;
  logic        regOpNext;
  logic [4:0]  regOpSel;
  always_comb begin
    regOpNext = 1'b0;
    regOpSel  = addrRegSel;
    eaNext    = 32'h00000000;
    case (eaMode)
      cpu_regs_pkg::AM_DREG, cpu_regs_pkg::AM_AREG: begin
        regOpNext = 1'b1;
        eaNext    = baseVal;
      end
      cpu_regs_pkg::AM_IND:       eaNext = baseVal;
      cpu_regs_pkg::AM_POSTINC:   eaNext = baseVal;
      cpu_regs_pkg::AM_PREDEC:    eaNext = preVal;
      cpu_regs_pkg::AM_DISP,
      cpu_regs_pkg::AM_INDEX,
      cpu_regs_pkg::AM_PC_DISP,
      cpu_regs_pkg::AM_PC_INDEX:  eaNext = dispSum;
      cpu_regs_pkg::AM_ABS_SHORT: eaNext = {{16{extWord0[15]}}, extWord0};
      cpu_regs_pkg::AM_ABS_LONG:  eaNext = {extWord0, extWord1};
      cpu_regs_pkg::AM_IMPLIED:   eaNext = impVal;
      default:                    eaNext = 32'h00000000;
    endcase
  end

  // Word and long operands must sit at even addresses
  wire memMode  = eaReq && !regOpNext && (eaMode != cpu_regs_pkg::AM_IMPLIED);
  wire oddNext  = memMode && (eaSize != cpu_regs_pkg::SZ_BYTE) && eaNext[0];

  // Register write data merge by size
  function automatic logic [31:0] mergeWr(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [1:0] sz, input logic isAddr);
    if (isAddr)
      mergeWr = (sz == cpu_regs_pkg::SZ_LONG) ? nw : {{16{nw[15]}}, nw[15:0]};
    else if (sz == cpu_regs_pkg::SZ_BYTE)
      mergeWr = {old[31:8], nw[7:0]};
    else if (sz == cpu_regs_pkg::SZ_WORD)
      mergeWr = {old[31:16], nw[15:0]};
    else
      mergeWr = nw;
  endfunction : mergeWr

  // Register file update; address update from the modes wins on clash
  genvar gi;
  generate
    for (gi = 0; gi < 17; gi++) begin : gReg
      localparam logic [4:0] IDX = 5'(gi);
      wire adjHit = (isPost || isPre) && (baseSlot == IDX);
      wire wrHit  = regWe && (wrSlot == IDX);
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          regs_q[gi] <= 32'h00000000;
        end else if (adjHit) begin
          regs_q[gi] <= isPre ? preVal : postVal;
        end else if (wrHit) begin
          regs_q[gi] <= mergeWr(regs_q[gi], regWrData, regWrSize, gi >= 8);
        end
      end
    end
  endgenerate

  // Program counter, kept even
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= cpu_regs_pkg::PC_RESET;
    end else if (pcWe) begin
      pc_q <= {pcWrData[31:1], 1'b0};
    end
  end

  // State word: full load, or condition flags only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psw_q <= cpu_regs_pkg::PSW_RESET;
    end else if (pswWe) begin
      psw_q <= pswWrData & cpu_regs_pkg::PSW_MASK;
    end else if (ccrWe) begin
      psw_q[cpu_regs_pkg::PSW_X:cpu_regs_pkg::PSW_C] <= ccrWrData;
    end
  end

  // Result registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eaValid         <= 1'b0;
      operandLocation <= 32'h00000000;
      busAddr         <= 24'h000000;
      isRegOperand    <= 1'b0;
      operandReg      <= 5'h00;
      alignErr        <= 1'b0;
      regRdData       <= 32'h00000000;
    end else begin
      eaValid         <= eaReq;
      operandLocation <= eaReq ? eaNext : operandLocation;
      busAddr         <= eaReq ? eaNext[23:0] : busAddr;
      isRegOperand    <= eaReq ? regOpNext : isRegOperand;
      operandReg      <= eaReq ? regOpSel : operandReg;
      alignErr        <= oddNext;
      regRdData       <= (rdSlot < cpu_regs_pkg::NUM_REG) ? regs_q[rdSlot] : 32'h00000000;
    end
  end

  // Mirrors of program counter and state word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      progCounter        <= cpu_regs_pkg::PC_RESET;
      processorStateWord <= cpu_regs_pkg::PSW_RESET;
      intMask            <= cpu_regs_pkg::PSW_RESET[10:8];
      supervisorMode     <= cpu_regs_pkg::PSW_RESET[13];
      traceMode          <= cpu_regs_pkg::PSW_RESET[15];
    end else begin
      progCounter        <= pc_q;
      processorStateWord <= psw_q;
      intMask            <= psw_q[cpu_regs_pkg::PSW_IM_HI:cpu_regs_pkg::PSW_IM_LO];
      supervisorMode     <= psw_q[cpu_regs_pkg::PSW_S];
      traceMode          <= psw_q[cpu_regs_pkg::PSW_T];
    end
  end
endmodule : cpu_regs_ea
`default_nettype wire

// file: bench/cpu_regs_ea_monitor.sv
// Checker on the ports of the register set and operand address generator.
// Assumes one clock domain, mclk, and rst_n asynchronous and active low.
`timescale 1ns/100ps
`default_nettype none
module cpu_regs_ea_monitor (
  input wire logic        mclk,               // Clock
  input wire logic        rst_n,              // Reset, active low
  input wire logic        eaReq,              // Request
  input wire logic [3:0]  eaMode,             // Address mode
  input wire logic [15:0] extWord0,           // First extension word
  input wire logic [15:0] extWord1,           // Second extension word
  input wire logic        pcWe,               // PC load
  input wire logic        pswWe,              // State word load
  input wire logic [15:0] pswWrData,          // State word data
  input wire logic        ccrWe,              // Flag load
  input wire logic [4:0]  ccrWrData,          // Flag data
  input wire logic        eaValid,            // Address ready
  input wire logic [31:0] operandLocation,    // Operand address
  input wire logic [23:0] busAddr,            // External address
  input wire logic        alignErr,           // Odd address flag
  input wire logic [31:0] progCounter,        // PC mirror
  input wire logic [15:0] processorStateWord, // State word mirror
  input wire logic [2:0]  intMask,            // Mask mirror
  input wire logic        supervisorMode,     // Privilege mirror
  input wire logic        traceMode           // Trace mirror
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Request timing and address shaping
  a_valid_follows_req: assert property (eaReq |=> eaValid)
    else $error("eaValid missing after request");
  a_valid_only_req: assert property (!eaReq |=> !eaValid)
    else $error("eaValid without request");
  a_bus_addr_low: assert property (eaValid |-> busAddr == operandLocation[23:0])
    else $error("busAddr differs from operand address");
  a_align_odd_only: assert property (alignErr |-> eaValid && operandLocation[0])
    else $error("alignErr on even address");
  a_abs_long_words: assert property (eaReq && eaMode == 4'h8 |=>
    operandLocation == $past({extWord0, extWord1})) else $error("absolute long wrong");
  a_abs_short_sext: assert property (eaReq && eaMode == 4'h7 |=>
    operandLocation == {{16{$past(extWord0[15])}}, $past(extWord0)})
    else $error("absolute short wrong");
  a_pc_disp_sum: assert property (eaReq && eaMode == 4'h9 && !$past(pcWe)
    && !$past(pcWe, 2) |=> operandLocation ==
    $past(progCounter) + {{16{$past(extWord0[15])}}, $past(extWord0)})
    else $error("PC displacement address wrong");
  // State word fields and loads
  a_mirror_fields: assert property (intMask == processorStateWord[10:8] &&
    supervisorMode == processorStateWord[13] && traceMode == processorStateWord[15])
    else $error("state word fields disagree");
  a_psw_load_mask: assert property (pswWe ##1 (!pswWe && !ccrWe) |=>
    processorStateWord == ($past(pswWrData, 2) & cpu_regs_pkg::PSW_MASK))
    else $error("state word load wrong");
  a_flag_load: assert property (ccrWe && !pswWe ##1 (!pswWe && !ccrWe) |=>
    processorStateWord[4:0] == $past(ccrWrData, 2)) else $error("flag load wrong");
  c_postinc: cover property (eaReq && eaMode == 4'h3);
  c_predec: cover property (eaReq && eaMode == 4'h4);
  c_align: cover property (alignErr);
endmodule : cpu_regs_ea_monitor
bind cpu_regs_ea cpu_regs_ea_monitor mon (.mclk(mclk), .rst_n(rst_n), .eaReq(eaReq),
  .eaMode(eaMode), .extWord0(extWord0), .extWord1(extWord1), .pcWe(pcWe), .pswWe(pswWe),
  .pswWrData(pswWrData), .ccrWe(ccrWe), .ccrWrData(ccrWrData), .eaValid(eaValid),
  .operandLocation(operandLocation), .busAddr(busAddr), .alignErr(alignErr),
  .progCounter(progCounter), .processorStateWord(processorStateWord), .intMask(intMask),
  .supervisorMode(supervisorMode), .traceMode(traceMode));
`default_nettype wire

// file: bench/ext_word_memory.sv
// Word memory holding the extension words that follow an instruction.
// Assumes the bench presents a byte address and reads the word at once.
`timescale 1ns/100ps
`default_nettype none
module ext_word_memory (
  input  wire logic [23:0] fetchAddr, // Byte address of the word
  output logic      [15:0] fetchData  // Word at that address
);
  logic [15:0] words [0:15];
  // Fixed contents, one word per even address
  initial begin
    for (int i = 0; i < 16; i++) words[i] = 16'h0f00 + 16'(i * 16'h0111);
  end
  // Bit 0 ignored: words sit at even addresses, the next one at n + 2
  assign fetchData = words[fetchAddr[4:1]];
endmodule : ext_word_memory
`default_nettype wire

// file: bench/cpu_regs_ea_tb.sv
// Self-checking bench for the register set and operand address generator.
// Assumes the design and checker files are compiled first; 8 ns clock.
`timescale 1ns/100ps
`default_nettype none
module cpu_regs_ea_tb;
  logic        mclk = 0, rst_n = 0, eaReq = 0, indexLong = 0, regWe = 0;
  logic        pcWe = 0, pswWe = 0, ccrWe = 0, eaValid, isRegOperand, alignErr;
  logic        supervisorMode, traceMode;
  logic [2:0]  intMask;
  logic [3:0]  eaMode = 0;
  logic [1:0]  eaSize = 0, impliedSel = 0, regWrSize = 0;
  logic [4:0]  addrRegSel = 0, indexReg = 0, regWrSel = 0, regRdSel = 0, ccrWrData = 0;
  logic [4:0]  operandReg;
  logic [15:0] extWord0 = 0, extWord1 = 0, pswWrData = 0, processorStateWord, memData, w0;
  logic [31:0] regWrData = 0, pcWrData = 0, regRdData, operandLocation, progCounter, a;
  logic [23:0] busAddr, memAddr = 0;
  int          fails = 0, comparisons = 0;
  cpu_regs_ea dut (
    .mclk(mclk), .rst_n(rst_n), .eaReq(eaReq), .eaMode(eaMode), .eaSize(eaSize),
    .addrRegSel(addrRegSel), .indexReg(indexReg), .indexLong(indexLong),
    .extWord0(extWord0), .extWord1(extWord1), .impliedSel(impliedSel), .regWe(regWe),
    .regWrSel(regWrSel), .regWrSize(regWrSize), .regWrData(regWrData), .pcWe(pcWe),
    .pcWrData(pcWrData), .pswWe(pswWe), .pswWrData(pswWrData), .ccrWe(ccrWe),
    .ccrWrData(ccrWrData), .regRdSel(regRdSel), .regRdData(regRdData), .eaValid(eaValid),
    .operandLocation(operandLocation), .busAddr(busAddr), .isRegOperand(isRegOperand),
    .operandReg(operandReg), .alignErr(alignErr), .progCounter(progCounter),
    .processorStateWord(processorStateWord), .intMask(intMask),
    .supervisorMode(supervisorMode), .traceMode(traceMode));
  ext_word_memory mem (.fetchAddr(memAddr), .fetchData(memData));
  // Free-running clock
  always #4 mclk = ~mclk;
  // Compare one value and count it
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Register write, one strobe cycle
  task automatic wreg(input logic [4:0] s, input logic [1:0] z, input logic [31:0] d);
    @(posedge mclk);
    regWe <= 1'b1;
    regWrSel <= s;
    regWrSize <= z;
    regWrData <= d;
    @(posedge mclk);
    regWe <= 1'b0;
  endtask : wreg
  // Register read, data one cycle after the select
  task automatic rreg(input logic [4:0] s, input logic [31:0] exp);
    @(posedge mclk);
    regRdSel <= s;
    @(posedge mclk);
    #1 cmp(regRdData, exp);
  endtask : rreg
  // PC, state word or flag load, then wait for the mirrors
  task automatic wsr(input logic [1:0] k, input logic [31:0] d);
    @(posedge mclk);
    pcWe <= (k == 2'd0);
    pswWe <= (k == 2'd1);
    ccrWe <= (k == 2'd2);
    pcWrData <= d;
    pswWrData <= d[15:0];
    ccrWrData <= d[4:0];
    @(posedge mclk);
    {pcWe, pswWe, ccrWe} <= 3'b000;
    @(posedge mclk);
    #1;
  endtask : wsr
  // Operand address request; ix is {long index, index select}, x is {ext0, ext1}
  task automatic locate(input logic [3:0] m, input logic [1:0] z, input logic [4:0] s,
                        input logic [5:0] ix, input logic [31:0] x, input logic [31:0] exp);
    @(posedge mclk);
    eaReq <= 1'b1;
    eaMode <= m;
    eaSize <= z;
    addrRegSel <= s;
    {indexLong, indexReg} <= ix;
    {extWord0, extWord1} <= x;
    @(posedge mclk);
    eaReq <= 1'b0;
    #1 cmp(operandLocation, exp);
    cmp({31'h0, eaValid}, 32'h1);
  endtask : locate
  // Verdict and end of run
  task automatic conclude;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Cuts a hang short
  initial begin
    #100000;
    fails++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    #1 cmp({16'h0, processorStateWord}, 32'h2700);
    for (int i = 0; i < 17; i++) wreg(5'(i), 2'd2, 32'h1000 + 32'h10 * i);
    for (int i = 0; i < 17; i++) rreg(5'(i), 32'h1000 + 32'h10 * i);
    wreg(5'd0, 2'd2, 32'h11223344);
    wreg(5'd0, 2'd0, 32'hffffffaa);
    rreg(5'd0, 32'h112233aa);
    wreg(5'd0, 2'd1, 32'h0000bbbb);
    rreg(5'd0, 32'h1122bbbb);
    wreg(5'd8, 2'd1, 32'h00008000);
    rreg(5'd8, 32'hffff8000);
    wreg(5'd8, 2'd0, 32'h000000f0);
    rreg(5'd8, 32'h000000f0);
    a = 32'h1090;
    for (int z = 0; z < 3; z++) begin
      locate(4'h3, 2'(z), 5'd9, 6'h0, 32'h0, a);
      a = a + (32'h1 << z);
    end
    rreg(5'd9, a);
    locate(4'h4, 2'd2, 5'd10, 6'h0, 32'h0, 32'h109c);
    rreg(5'd10, 32'h109c);
    locate(4'h3, 2'd0, 5'd15, 6'h0, 32'h0, 32'h10f0);
    rreg(5'd15, 32'h10f2);
    locate(4'h4, 2'd0, 5'd16, 6'h0, 32'h0, 32'h10fe);
    locate(4'h5, 2'd1, 5'd8, 6'h0, 32'hfffe0000, 32'h000000ee);
    locate(4'h6, 2'd1, 5'd9, 6'h00, 32'h12f00000, 32'hffffcc42);
    locate(4'h6, 2'd2, 5'd8, 6'h30, 32'h00040000, 32'h000011f2);
    locate(4'h2, 2'd1, 5'd9, 6'h0, 32'h0, 32'h1097);
    cmp({31'h0, alignErr}, 32'h1);
    locate(4'h2, 2'd2, 5'd10, 6'h0, 32'h0, 32'h109c);
    cmp({31'h0, alignErr}, 32'h0);
    locate(4'h7, 2'd1, 5'd0, 6'h0, 32'h80000000, 32'hffff8000);
    @(posedge mclk);
    memAddr <= 24'h000002;
    @(posedge mclk);
    #1 w0 = memData;
    memAddr <= 24'h000004;
    #1 locate(4'h8, 2'd2, 5'd0, 6'h0, {w0, memData}, 32'h10111122);
    wsr(2'd0, 32'h00002001);
    cmp(progCounter, 32'h00002000);
    locate(4'h9, 2'd1, 5'd0, 6'h0, 32'hff000000, 32'h00001f00);
    locate(4'ha, 2'd1, 5'd0, 6'h28, 32'h00800000, 32'h00002070);
    cmp({8'h0, busAddr}, 32'h00002070);
    cmp({31'h0, isRegOperand}, 32'h0);
    locate(4'h0, 2'd2, 5'd1, 6'h0, 32'h0, 32'h00001010);
    cmp({31'h0, isRegOperand}, 32'h1);
    cmp({27'h0, operandReg}, 32'h1);
    @(posedge mclk);
    impliedSel <= 2'd3;
    locate(4'hb, 2'd2, 5'd0, 6'h0, 32'h0, 32'h00002000);
    @(posedge mclk);
    impliedSel <= 2'd1;
    locate(4'hb, 2'd2, 5'd0, 6'h0, 32'h0, 32'h000010fe);
    wsr(2'd1, 32'h0000ffff);
    cmp({16'h0, processorStateWord}, 32'ha71f);
    cmp({31'h0, traceMode}, 32'h1);
    wsr(2'd1, 32'h00000300);
    cmp({29'h0, intMask}, 32'h3);
    cmp({31'h0, supervisorMode}, 32'h0);
    rreg(5'd15, 32'h10fe);
    wsr(2'd2, 32'h00000015);
    cmp({16'h0, processorStateWord}, 32'h0315);
    conclude();
  end
endmodule : cpu_regs_ea_tb
`default_nettype wire
